//--- pfei_pkg.sv
// Constants shared by the fault event interrupt block
package pfei_pkg;

	localparam int REG_W  = 8;
	localparam int ADDR_W = 8;

	// Register offsets
	localparam logic [ADDR_W-1:0] THERM_MASK_ADDR  = 8'h05;
	localparam logic [ADDR_W-1:0] RAIL_MASK_ADDR   = 8'h06;
	localparam logic [ADDR_W-1:0] THERM_FLAGS_ADDR = 8'h07;
	localparam logic [ADDR_W-1:0] RAIL_FLAGS_ADDR  = 8'h08;

	// Reset values and writable bits
	localparam logic [REG_W-1:0] THERM_MASK_RESET    = 8'h7f;
	localparam logic [REG_W-1:0] THERM_MASK_WRITABLE = 8'h7c;
	localparam logic [REG_W-1:0] RAIL_MASK_RESET     = 8'hff;
	localparam logic [REG_W-1:0] RAIL_MASK_WRITABLE  = 8'hff;
	localparam logic [REG_W-1:0] UNMAPPED_READ       = 8'h00;

	// Thermal and calibration flag positions
	localparam int BIT_TEMP_CHANGE   = 7;
	localparam int BIT_SHUTDOWN      = 6;
	localparam int BIT_EARLY_WARN    = 5;
	localparam int BIT_THERM_HOT     = 4;
	localparam int BIT_THERM_COLD    = 3;
	localparam int BIT_INPUT_UV      = 2;
	localparam int BIT_KICKBACK_DONE = 1;
	localparam int BIT_CALIB_STORE   = 0;

	// Rail fault flag positions
	localparam int BIT_BOOST_UV      = 7;
	localparam int BIT_POS_PUMP_UV   = 6;
	localparam int BIT_INVERT_UV     = 5;
	localparam int BIT_POS_LDO_UV    = 4;
	localparam int BIT_NEG_PUMP_UV   = 3;
	localparam int BIT_COMMON_FAULT  = 2;
	localparam int BIT_NEG_LDO_UV    = 1;
	localparam int BIT_CONV_DONE     = 0;

	// Asynchronous fault pins, index in the synchroniser vector
	localparam int ASYNC_W           = 10;
	localparam int PIN_SHUTDOWN      = 0;
	localparam int PIN_EARLY_WARN    = 1;
	localparam int PIN_INPUT_UV      = 2;
	localparam int PIN_BOOST_UV      = 3;
	localparam int PIN_POS_PUMP_UV   = 4;
	localparam int PIN_INVERT_UV     = 5;
	localparam int PIN_POS_LDO_UV    = 6;
	localparam int PIN_NEG_PUMP_UV   = 7;
	localparam int PIN_COMMON_FAULT  = 8;
	localparam int PIN_NEG_LDO_UV    = 9;

	// Least temperature step, degrees, that counts as a change
	localparam logic signed [8:0] TEMP_DELTA_MIN = 9'sh003;

endpackage

//--- pfei_flag_if.sv
// Set, clear and flag signals between the core and a flag bank
`timescale 1ns/1ps
interface pfei_flag_if #(
	parameter int WIDTH = 8
);
	logic [WIDTH-1:0] set;
	logic             clr;
	logic [WIDTH-1:0] flags;

	modport bank (
		input  set,
		input  clr,
		output flags
	);
	modport user (
		output set,
		output clr,
		input  flags
	);
endinterface

//--- pfei_flag_bank.sv
// Sticky event flags, cleared as a group, set wins over clear
`timescale 1ns/1ps
module pfei_flag_bank #(
	parameter int WIDTH = 8
) (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic clk_en,
	pfei_flag_if.bank port
);
	import pfei_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] flags;
	} pfei_bank_state_t;

	pfei_bank_state_t state;
	pfei_bank_state_t next_state;
	logic [WIDTH-1:0] next_bits;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			// A source still active during the read keeps its flag
			assign next_bits[i] = port.set[i] | (state.flags[i] & ~port.clr);
		end
	endgenerate

	assign port.flags = state.flags;

	always_comb begin
		next_state = state;
		if (clk_en) begin
			next_state.flags = next_bits;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end
endmodule

//--- pfei_core.sv
// Fault event flags, enable masks and interrupt pin of the power device
// Notes on behaviour
// - Enabled pending event pulls interrupt pin low
// - Disabled events never pull the pin low
// - Rail enable register at 0x06, resets all ones
// - Temperature step of three degrees sets flag
// - Shutdown flag follows overtemperature shutdown state
// - Early warning flag precedes shutdown flag
// - Thermistor at or above hot limit flags
// - Thermistor at or below cold limit flags
// - Input undervoltage flag while supply below lockout
// - Kick-back measurement done sets flag
// - Calibration stored to nonvolatile memory sets flag
// - Boost converter undervoltage sets rail bit 7
// - Positive gate pump undervoltage sets bit 6
// - Inverting converter undervoltage sets bit 5
// - Positive source regulator undervoltage sets bit 4
// - Negative gate pump undervoltage sets bit 3
// - Common electrode out of range sets bit 2
// - Negative source regulator undervoltage sets bit 1
// - Temperature conversion done sets bit 0
// - Thermal flag register ignores host writes
// - Thermal enable register gates matching flags
`timescale 1ns/1ps
module pfei_core (
	input  wire logic                       sys_clk,
	input  wire logic                       rst,
	input  wire logic                       clk_en,
	input  wire logic [pfei_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic                       reg_wr_en,
	input  wire logic [pfei_pkg::REG_W-1:0]  reg_wr_data,
	input  wire logic                       reg_rd_en,
	output logic      [pfei_pkg::REG_W-1:0]  reg_rd_data,
	input  wire logic [7:0]                 temp_reading,
	input  wire logic                       temp_valid,
	input  wire logic [7:0]                 therm_hot_limit,
	input  wire logic [7:0]                 therm_cold_limit,
	input  wire logic                       kickback_done,
	input  wire logic                       calib_store_done,
	input  wire logic                       shutdown_pin,
	input  wire logic                       early_warn_pin,
	input  wire logic                       input_uv_pin,
	input  wire logic                       boost_uv_pin,
	input  wire logic                       pos_gate_pump_uv_pin,
	input  wire logic                       invert_conv_uv_pin,
	input  wire logic                       pos_source_ldo_uv_pin,
	input  wire logic                       neg_gate_pump_uv_pin,
	input  wire logic                       common_electrode_fault_pin,
	input  wire logic                       neg_source_ldo_uv_pin,
	output logic                            irq_out_n
);
	import pfei_pkg::*;

	typedef struct packed {
		logic [ASYNC_W-1:0]  sync1;
		logic [ASYNC_W-1:0]  sync2;
		logic [ASYNC_W-1:0]  sync3;
		logic [ASYNC_W-1:0]  pin_level;
		logic [REG_W-1:0]    therm_mask;
		logic [REG_W-1:0]    rail_mask;
		logic [REG_W-1:0]    rd_data;
		logic signed [7:0]   last_temp;
		logic                have_last;
		logic                therm_hot_lvl;
		logic                therm_cold_lvl;
		logic                temp_change_ev;
		logic                conv_done_ev;
		logic                irq_n;
	} pfei_core_state_t;

	localparam pfei_core_state_t CORE_RESET = '{
		sync1:          '0,
		sync2:          '0,
		sync3:          '0,
		pin_level:      '0,
		therm_mask:     THERM_MASK_RESET,
		rail_mask:      RAIL_MASK_RESET,
		rd_data:        UNMAPPED_READ,
		last_temp:      '0,
		have_last:      1'b0,
		therm_hot_lvl:  1'b0,
		therm_cold_lvl: 1'b0,
		temp_change_ev: 1'b0,
		conv_done_ev:   1'b0,
		irq_n:          1'b1
	};

	pfei_core_state_t state;
	pfei_core_state_t next_state;

	pfei_flag_if #(.WIDTH(REG_W)) therm_if ();
	pfei_flag_if #(.WIDTH(REG_W)) rail_if ();

	pfei_flag_bank #(.WIDTH(REG_W)) u_therm_flags (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.port    (therm_if.bank)
	);

	pfei_flag_bank #(.WIDTH(REG_W)) u_rail_flags (
		.sys_clk (sys_clk),
		.rst     (rst),
		.clk_en  (clk_en),
		.port    (rail_if.bank)
	);

	logic [ASYNC_W-1:0] pins_raw;
	logic [REG_W-1:0]   therm_set;
	logic [REG_W-1:0]   rail_set;
	logic               rd_therm;
	logic               rd_rail;
	logic signed [8:0]  temp_diff;
	logic signed [8:0]  temp_mag;
	logic               temp_step;
	logic [REG_W-1:0]   pending;

	always_comb begin
		pins_raw                   = '0;
		pins_raw[PIN_SHUTDOWN]     = shutdown_pin;
		pins_raw[PIN_EARLY_WARN]   = early_warn_pin;
		pins_raw[PIN_INPUT_UV]     = input_uv_pin;
		pins_raw[PIN_BOOST_UV]     = boost_uv_pin;
		pins_raw[PIN_POS_PUMP_UV]  = pos_gate_pump_uv_pin;
		pins_raw[PIN_INVERT_UV]    = invert_conv_uv_pin;
		pins_raw[PIN_POS_LDO_UV]   = pos_source_ldo_uv_pin;
		pins_raw[PIN_NEG_PUMP_UV]  = neg_gate_pump_uv_pin;
		pins_raw[PIN_COMMON_FAULT] = common_electrode_fault_pin;
		pins_raw[PIN_NEG_LDO_UV]   = neg_source_ldo_uv_pin;
	end

	// Magnitude of the step between successive temperature readings
	always_comb begin
		temp_diff = $signed({temp_reading[7], temp_reading})
			- $signed({state.last_temp[7], state.last_temp});
		temp_mag  = (temp_diff < 0) ? -temp_diff : temp_diff;
		temp_step = temp_valid & state.have_last
			& (temp_mag >= TEMP_DELTA_MIN);
	end

	// Sources of the thermal and calibration flags
	always_comb begin
		therm_set                    = '0;
		therm_set[BIT_TEMP_CHANGE]   = state.temp_change_ev;
		therm_set[BIT_SHUTDOWN]      = state.pin_level[PIN_SHUTDOWN];
		therm_set[BIT_EARLY_WARN]    = state.pin_level[PIN_EARLY_WARN];
		therm_set[BIT_THERM_HOT]     = state.therm_hot_lvl;
		therm_set[BIT_THERM_COLD]    = state.therm_cold_lvl;
		therm_set[BIT_INPUT_UV]      = state.pin_level[PIN_INPUT_UV];
		therm_set[BIT_KICKBACK_DONE] = kickback_done;
		therm_set[BIT_CALIB_STORE]   = calib_store_done;
	end

	// Sources of the rail fault flags
	always_comb begin
		rail_set                   = '0;
		rail_set[BIT_BOOST_UV]     = state.pin_level[PIN_BOOST_UV];
		rail_set[BIT_POS_PUMP_UV]  = state.pin_level[PIN_POS_PUMP_UV];
		rail_set[BIT_INVERT_UV]    = state.pin_level[PIN_INVERT_UV];
		rail_set[BIT_POS_LDO_UV]   = state.pin_level[PIN_POS_LDO_UV];
		rail_set[BIT_NEG_PUMP_UV]  = state.pin_level[PIN_NEG_PUMP_UV];
		rail_set[BIT_COMMON_FAULT] = state.pin_level[PIN_COMMON_FAULT];
		rail_set[BIT_NEG_LDO_UV]   = state.pin_level[PIN_NEG_LDO_UV];
		rail_set[BIT_CONV_DONE]    = state.conv_done_ev;
	end

	// A read of a flag register clears it; set still wins in the bank
	assign rd_therm = clk_en & reg_rd_en & (reg_addr == THERM_FLAGS_ADDR);
	assign rd_rail  = clk_en & reg_rd_en & (reg_addr == RAIL_FLAGS_ADDR);

	assign therm_if.set = therm_set;
	assign therm_if.clr = rd_therm;
	assign rail_if.set  = rail_set;
	assign rail_if.clr  = rd_rail;

	// Only flags whose enable bit is 1 reach the pin
	assign pending = (therm_if.flags & state.therm_mask)
		| (rail_if.flags & state.rail_mask);

	always_comb begin
		next_state = state;
		if (clk_en) begin
			// Three stages; a level counts once stages two and three agree
			next_state.sync1 = pins_raw;
			next_state.sync2 = state.sync1;
			next_state.sync3 = state.sync2;
			next_state.pin_level = (state.sync2 & state.sync3)
				| (state.pin_level & (state.sync2 | state.sync3));

			// One-cycle events from a completed temperature conversion
			next_state.conv_done_ev   = temp_valid;
			next_state.temp_change_ev = temp_step;
			if (temp_valid) begin
				// First reading after reset has nothing to compare with
				next_state.last_temp      = $signed(temp_reading);
				next_state.have_last      = 1'b1;
				next_state.therm_hot_lvl  = $signed(temp_reading)
					>= $signed(therm_hot_limit);
				next_state.therm_cold_lvl = $signed(temp_reading)
					<= $signed(therm_cold_limit);
			end

			// Flag registers take no writes
			if (reg_wr_en) begin
				case (reg_addr)
					THERM_MASK_ADDR: begin
						next_state.therm_mask =
							(state.therm_mask & ~THERM_MASK_WRITABLE)
							| (reg_wr_data & THERM_MASK_WRITABLE);
					end
					RAIL_MASK_ADDR: begin
						next_state.rail_mask =
							(state.rail_mask & ~RAIL_MASK_WRITABLE)
							| (reg_wr_data & RAIL_MASK_WRITABLE);
					end
					default: begin
						next_state.rail_mask = state.rail_mask;
					end
				endcase
			end

			// Read data shows flags as they stood before the clear
			if (reg_rd_en) begin
				case (reg_addr)
					THERM_MASK_ADDR:  next_state.rd_data = state.therm_mask;
					RAIL_MASK_ADDR:   next_state.rd_data = state.rail_mask;
					THERM_FLAGS_ADDR: next_state.rd_data = therm_if.flags;
					RAIL_FLAGS_ADDR:  next_state.rd_data = rail_if.flags;
					default:          next_state.rd_data = UNMAPPED_READ;
				endcase
			end

			// Pin stays low while any enabled flag is pending
			next_state.irq_n = ~|pending;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state <= CORE_RESET;
		end else begin
			state <= next_state;
		end
	end

	assign reg_rd_data = state.rd_data;
	assign irq_out_n   = state.irq_n;
endmodule

//--- pfei_core_properties.sv
// Port assertions for the fault event interrupt block
`timescale 1ns/1ps
module pfei_core_properties (
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic       clk_en,
	input wire logic [7:0] reg_addr,
	input wire logic       reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic       reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic       temp_valid,
	input wire logic       kickback_done,
	input wire logic       calib_store_done,
	input wire logic       shutdown_pin,
	input wire logic       boost_uv_pin,
	input wire logic       irq_out_n
);
	import pfei_pkg::*;
	logic [7:0] tmask;
	logic [7:0] rmask;
	// Shadow masks, the real ones are not visible here
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tmask <= THERM_MASK_RESET;
			rmask <= RAIL_MASK_RESET;
		end else if (clk_en && reg_wr_en) begin
			if (reg_addr == THERM_MASK_ADDR)
				tmask <= tmask & ~THERM_MASK_WRITABLE
					| reg_wr_data & THERM_MASK_WRITABLE;
			if (reg_addr == RAIL_MASK_ADDR)
				rmask <= reg_wr_data;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	AST_CALIB_IRQ:
		assert property (clk_en && calib_store_done ##1 clk_en |=> !irq_out_n)
		else $error("calib store gave no interrupt");
	AST_KICKBACK_IRQ:
		assert property (clk_en && kickback_done ##1 clk_en |=> !irq_out_n)
		else $error("kick-back done gave no interrupt");
	AST_CONV_DONE_IRQ:
		assert property (clk_en && temp_valid && rmask[0] ##1 clk_en [*2]
			|=> !irq_out_n)
		else $error("conversion done gave no interrupt");
	AST_SHUTDOWN_IRQ:
		assert property ((clk_en && shutdown_pin && tmask[6]) [*8]
			|-> !irq_out_n)
		else $error("shutdown gave no interrupt");
	AST_BOOST_IRQ:
		assert property ((clk_en && boost_uv_pin && rmask[7]) [*8]
			|-> !irq_out_n)
		else $error("boost undervoltage gave no interrupt");
	AST_IRQ_HOLDS:
		assert property (!irq_out_n && !reg_rd_en && !reg_wr_en
			&& !$past(reg_rd_en) && !$past(reg_wr_en) |=> !irq_out_n)
		else $error("interrupt released without a read");
	AST_RAIL_MASK_READ:
		assert property (clk_en && reg_rd_en && reg_addr == RAIL_MASK_ADDR
			|=> reg_rd_data == $past(rmask))
		else $error("rail mask read wrong");
	AST_THERM_MASK_READ:
		assert property (clk_en && reg_rd_en && reg_addr == THERM_MASK_ADDR
			|=> reg_rd_data == $past(tmask))
		else $error("thermal mask read wrong");
endmodule
bind pfei_core pfei_core_properties i_props (.*);

//--- pfei_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
module pfei_host_model (
	input  wire logic       sys_clk,
	output logic      [7:0] reg_addr = 8'h00,
	output logic            reg_wr_en = 1'b0,
	output logic      [7:0] reg_wr_data = 8'h00,
	output logic            reg_rd_en = 1'b0,
	input  wire logic [7:0] reg_rd_data,
	input  wire logic       irq_out_n
);
	// Released lines show the inverse, never the last value
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge sys_clk);
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wr_data = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge sys_clk);
		reg_rd_en = 1'b0;
		reg_addr = ~a;
		d = reg_rd_data;
	endtask
	task automatic service;
		logic [7:0] f;
		for (int n = 0; n < 4 && !irq_out_n; n++) begin
			rd(pfei_pkg::THERM_FLAGS_ADDR, f);
			rd(pfei_pkg::RAIL_FLAGS_ADDR, f);
		end
	endtask
endmodule

//--- pfei_core_tb_top.sv
// Self-checking bench for the fault event interrupt block
`timescale 1ns/1ps
module pfei_core_tb_top;
	import pfei_pkg::*;
	localparam int          HOT = 20;
	localparam int          COLD = -10;
	localparam logic [15:0] EVT = 16'hfe67;
	logic              sys_clk = 1'b0;
	logic              rst = 1'b1;
	logic        [7:0] rail_pin = 8'h00;
	logic        [7:0] th_pin = 8'h00;
	logic        [7:0] temp_reading = 8'h00;
	logic              temp_valid = 1'b0;
	logic              clk_en = 1'b1;
	logic        [7:0] reg_addr, reg_wr_data, reg_rd_data, got, em;
	logic              reg_wr_en, reg_rd_en, irq_out_n;
	logic signed [7:0] r, prv;
	logic signed [7:0] tv [5] = '{8'sd10, 8'sd20, 8'sd22, -8'sd10, -8'sd7};
	logic        [7:0] rst_exp [6] = '{8'h00, 8'h7f, 8'hff, 8'h00, 8'h00,
		8'h00};
	int                errors = 0;
	int                cmp_count = 0;
	int                seed = 63;
	int                b;
	always #50 sys_clk = ~sys_clk;
	pfei_host_model i_host (.*);
	pfei_core i_dut (.*, .therm_hot_limit(8'(HOT)),
		.therm_cold_limit(8'(COLD)), .kickback_done(th_pin[1]),
		.calib_store_done(th_pin[0]), .shutdown_pin(th_pin[6]),
		.early_warn_pin(th_pin[5]), .input_uv_pin(th_pin[2]),
		.boost_uv_pin(rail_pin[7]), .pos_gate_pump_uv_pin(rail_pin[6]),
		.invert_conv_uv_pin(rail_pin[5]), .pos_source_ldo_uv_pin(rail_pin[4]),
		.neg_gate_pump_uv_pin(rail_pin[3]),
		.common_electrode_fault_pin(rail_pin[2]),
		.neg_source_ldo_uv_pin(rail_pin[1]));
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task automatic chk(input string n, input logic [7:0] s, e);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Sticky level of the old reading survives until the next read
	function automatic logic [7:0] exp_th(input logic signed [7:0] p, q,
		input logic first);
		logic signed [8:0] d;
		d = q - p;
		exp_th = 8'h00;
		exp_th[7] = !first && (d >= 3 || d <= -3);
		exp_th[4] = q >= HOT || !first && p >= HOT;
		exp_th[3] = q <= COLD || !first && p <= COLD;
	endfunction
	initial begin
		cyc(3);
		rst = 1'b0;
		i_host.wr(THERM_FLAGS_ADDR, 8'hff);
		i_host.wr(RAIL_FLAGS_ADDR, 8'hff);
		for (int a = 4; a < 10; a++) begin
			i_host.rd(8'(a), got);
			chk("reset", got, rst_exp[a-4]);
		end
		for (int i = 0; i < 9; i++) begin
			r = i < 5 ? tv[i] : i < 8 ? 8'($random(seed) % 41) : 8'sd0;
			i_host.rd(THERM_FLAGS_ADDR, got);
			temp_reading = r;
			temp_valid = 1'b1;
			cyc(1);
			temp_valid = 1'b0;
			cyc(4);
			i_host.rd(THERM_FLAGS_ADDR, got);
			chk("therm", got, exp_th(prv, r, i == 0));
			i_host.rd(RAIL_FLAGS_ADDR, got);
			chk("conv", got, 8'h01);
			prv = r;
		end
		i_host.service();
		cyc(2);
		chk("irq", 8'(irq_out_n), 8'h01);
		// Frozen clock enable must swallow a done pulse
		clk_en = 1'b0;
		th_pin[0] = 1'b1;
		cyc(1);
		th_pin[0] = 1'b0;
		cyc(2);
		clk_en = 1'b1;
		cyc(2);
		chk("frozen irq", 8'(irq_out_n), 8'h01);
		i_host.rd(THERM_FLAGS_ADDR, got);
		chk("frozen flags", got, 8'h00);
		for (int k = 0; k < 16; k++) begin
			b = k % 8;
			if (!EVT[k])
				continue;
			em = 8'($random(seed));
			if (k > 7) begin
				i_host.wr(RAIL_MASK_ADDR, em);
				i_host.rd(RAIL_MASK_ADDR, got);
				chk("rmask", got, em);
				rail_pin[b] = 1'b1;
			end else begin
				i_host.wr(THERM_MASK_ADDR, em);
				em = em & THERM_MASK_WRITABLE | 8'h03;
				i_host.rd(THERM_MASK_ADDR, got);
				chk("tmask", got, em);
				th_pin[b] = 1'b1;
			end
			cyc(k < 2 ? 1 : 8);
			rail_pin = 8'h00;
			th_pin = 8'h00;
			cyc(6);
			chk("irq", irq_out_n, 8'(!em[b]));
			i_host.rd(k > 7 ? RAIL_FLAGS_ADDR : THERM_FLAGS_ADDR, got);
			if (k > 7)
				chk("rail", got, 8'h01 << b);
			else
				chk("therm", got, 8'h01 << b);
			cyc(3);
			chk("irq", 8'(irq_out_n), 8'h01);
		end
		// Mid-run reset must bring the rail enables back to all ones
		i_host.wr(RAIL_MASK_ADDR, 8'h00);
		rst = 1'b1;
		cyc(2);
		rst = 1'b0;
		i_host.rd(RAIL_MASK_ADDR, got);
		chk("rereset rmask", got, RAIL_MASK_RESET);
		i_host.rd(THERM_MASK_ADDR, got);
		chk("rereset tmask", got, THERM_MASK_RESET);
		chk("rereset irq", 8'(irq_out_n), 8'h01);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		errors++;
		end_sim();
	end
endmodule
